// [hdl/pfc_freq_counter.sv]
`timescale 1ns/1ns
module pfc_freq_counter
  import pfc_pkg::*;
#(
  parameter int LOCK_TMO_CYC = PFC_LOCK_TMO_CYC
)
(
  input  wire logic                  ref_clk_in,
  input  wire logic                  sys_rst_in,
  // apb slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [PFC_ADDR_W-1:0] paddr_in,
  input  wire logic [PFC_DATA_W-1:0] pwdata_in,
  output logic      [PFC_DATA_W-1:0] prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // analog side signals
  input  wire logic                  error_beat_in,
  input  wire logic                  search_osc_in,
  input  wire logic                  drift_up_in,
  input  wire logic                  drift_down_in,
  output logic                       drift_up_out,
  output logic                       drift_down_out,
  output logic                       lock_out,
  output logic                       count_complete_out,
  output logic                       talk_select_strobe_n_out
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  // fields of the one state register
  // prescale : beat divider, bit 3 gates the counter, bit 4 ends the gate
  // seq      : readout buffer sequencer, saturates at idle
  // lock_tmr : one-shot timer, nonzero while searching
  // listen   : last byte written to the listen address
  // rdata    : read data, loaded in the setup cycle
  // talk_act : talk strobe, high through the access of a talk read
  typedef struct packed {
    logic [PFC_PRE_W-1:0]  prescale;
    logic [1:0]            seq;
    logic [PFC_LOCK_W-1:0] lock_tmr;
    logic [7:0]            listen;
    logic [PFC_DATA_W-1:0] rdata;
    logic                  talk_act;
  } pfc_state_t;

  pfc_state_t st_reg;
  pfc_state_t st_next;

  localparam logic [PFC_LOCK_W-1:0] LOCK_LOAD = PFC_LOCK_W'(LOCK_TMO_CYC);

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  // both pins are free running, so every edge is taken only after two
  // flops; the beat edge lags the pin by three reference clocks, which
  // shifts the gate in time but keeps its length at eight beat periods
  logic beat_fall;
  logic osc_fall;
  logic osc_rise;

  // beat brought into the reference domain
  pfc_edge_sync u_beat_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (error_beat_in),
    .level_out  (),
    .fall_out   (beat_fall),
    .rise_out   ()
  );

  // search oscillation brought into the reference domain
  pfc_edge_sync u_osc_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (search_osc_in),
    .level_out  (),
    .fall_out   (osc_fall),
    .rise_out   (osc_rise)
  );

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic apb_setup;
  logic apb_access;
  logic hit_talk;
  logic hit_listen;
  logic wr_listen;
  logic talk_done;
  logic clear_cmd;
  logic seq_rst_cmd;

  assign hit_talk    = (paddr_in == PFC_TALK_ADDR);
  assign hit_listen  = (paddr_in == PFC_LISTEN_ADDR);
  assign apb_setup   = psel_in & ~penable_in;
  assign apb_access  = psel_in & penable_in;
  assign wr_listen   = apb_access & pwrite_in & hit_listen;
  // talk read completes when the strobe is released
  assign talk_done   = apb_access & ~pwrite_in & hit_talk;
  assign clear_cmd   = wr_listen & pwdata_in[PFC_CLEAR_POS];
  assign seq_rst_cmd = wr_listen & pwdata_in[PFC_SEQ_RST_POS];

  // the talk address only answers reads; a write to it is dropped with
  // no error, so it cannot disturb the sequencer
  // zero wait states, error on unmapped address
  assign pready_out  = 1'b1;
  assign pslverr_out = apb_access & ~(hit_talk | hit_listen);

  // ----------------------------------------------------------------------
  // prescaler and gate
  // ----------------------------------------------------------------------
  // the divider stops itself: once bit 4 is set the selector shuts, no
  // further beat edge is taken and the taps freeze until the next clear
  logic div8_tap;
  logic div16_tap;
  logic sel_open;
  logic ref_gate;

  assign div8_tap  = st_reg.prescale[PFC_DIV8_POS];
  assign div16_tap = st_reg.prescale[PFC_DIV16_POS];
  assign sel_open  = ~div16_tap;
  assign ref_gate  = div8_tap & ~div16_tap & ~clear_cmd;

  // ----------------------------------------------------------------------
  // main counter, five cascaded stages
  // ----------------------------------------------------------------------
  // a beat slow enough to fill all five stages wraps the count
  // silently; there is no overflow flag, so software must keep the
  // beat above that limit before trusting the result
  logic [PFC_STAGES:0]        carry;
  logic [PFC_COUNT_W-1:0]     count;

  assign carry[0] = ref_gate;

  for (genvar g = 0; g < PFC_STAGES; g++) begin : g_stage
    pfc_nibble_stage #(
      .W (PFC_STAGE_W)
    ) u_stage (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .clear_in   (clear_cmd),
      .carry_in   (carry[g]),
      .count_out  (count[g*PFC_STAGE_W +: PFC_STAGE_W]),
      .carry_out  (carry[g+1])
    );
  end

  // ----------------------------------------------------------------------
  // lock sensor and drift lines
  // ----------------------------------------------------------------------
  // the timer doubles as the one-shot: zero means timed out, so reset
  // leaves the block reporting lock until the first oscillation edge;
  // the drift lines are therefore open straight after reset
  logic searching;
  logic locked;

  assign searching = (st_reg.lock_tmr != '0);
  assign locked    = ~searching;

  assign drift_up_out   = drift_up_in & locked;
  assign drift_down_out = drift_down_in & locked;

  // ----------------------------------------------------------------------
  // readout buffers
  // ----------------------------------------------------------------------
  // nibbles and bytes come straight from the live counter; they are
  // only meaningful once count complete has been seen high
  logic [7:0] status_byte;
  logic [7:0] sel_byte;

  // status byte carries flags and the top nibble
  always_comb begin
    status_byte                   = {4'h0, count[PFC_COUNT_W-1 -: PFC_STAGE_W]};
    status_byte[PFC_ST_VALID_POS] = div16_tap;
    status_byte[PFC_ST_UP_POS]    = drift_up_in;
    status_byte[PFC_ST_DOWN_POS]  = drift_down_in;
    status_byte[PFC_ST_LOCK_POS]  = locked;
  end

  // one buffer chosen by the sequencer
  always_comb begin
    unique case (st_reg.seq)
      PFC_SEQ_STATUS: sel_byte = status_byte;
      PFC_SEQ_MID:    sel_byte = count[15:8];
      PFC_SEQ_LAST:   sel_byte = count[7:0];
      PFC_SEQ_IDLE:   sel_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // prescaler: clear, else step on falling beat while selector open
    // a clear in the same cycle as a beat edge wins
    if (clear_cmd) begin
      st_next.prescale = '0;
    end else if (beat_fall && sel_open) begin
      st_next.prescale = st_reg.prescale + 1'b1;
    end

    // one-shot retriggered on every oscillation edge
    // a steady line lets the timer run down to lock
    if (osc_fall || osc_rise) begin
      st_next.lock_tmr = LOCK_LOAD;
    end else if (searching) begin
      st_next.lock_tmr = st_reg.lock_tmr - 1'b1;
    end

    // listen data latch
    // kept so software can read the last command back
    if (wr_listen) begin
      st_next.listen = pwdata_in[7:0];
    end

    // talk strobe active during access of a talk read
    // set from the setup cycle, so it stands low for the whole access
    // and rises as that access ends
    st_next.talk_act = 1'b0;
    if (apb_setup && !pwrite_in && hit_talk) begin
      st_next.talk_act = 1'b1;
    end

    // read data is prepared in the setup cycle
    // a talk read clears it after the access, so a freed bus reads zero
    if (apb_setup && !pwrite_in) begin
      if (hit_talk) begin
        st_next.rdata = {24'h000000, sel_byte};
      end else if (hit_listen) begin
        st_next.rdata = {24'h000000, st_reg.listen};
      end else begin
        st_next.rdata = '0;
      end
    end else if (talk_done) begin
      st_next.rdata = '0;
    end

    // sequencer: reset on listen command, advance on strobe release
    // saturates at idle; later talk reads give zero until bit 3 is sent
    if (seq_rst_cmd) begin
      st_next.seq = PFC_SEQ_STATUS;
    end else if (talk_done && st_reg.seq != PFC_SEQ_IDLE) begin
      st_next.seq = st_reg.seq + 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // listen byte and sequencer take their own reset values, the rest
  // clears to zero
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_reg          <= '0;
      st_reg.listen   <= PFC_LISTEN_RST;
      st_reg.seq      <= PFC_SEQ_STATUS;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // count complete is the div16 tap itself, so it falls in the cycle
  // after a clear and rises with the sixteenth taken beat edge;
  // lock and drift lines follow the timer without further delay
  assign prdata_out               = st_reg.rdata;
  assign lock_out                 = locked;
  assign count_complete_out       = div16_tap;
  assign talk_select_strobe_n_out = ~st_reg.talk_act;

endmodule

// [hdl/pfc_pkg.sv]
// ----------------------------------------------------------------------
// shared constants for the phaselock error frequency counter
// ----------------------------------------------------------------------
package pfc_pkg;

  // apb bus geometry
  localparam int          PFC_ADDR_W        = 12;
  localparam int          PFC_DATA_W        = 32;

  // register indices as printed, byte address is four times the index
  localparam logic [7:0]  PFC_TALK_IDX      = 8'hF3;
  localparam logic [7:0]  PFC_LISTEN_IDX    = 8'h73;
  localparam logic [11:0] PFC_TALK_ADDR     = {2'h0, PFC_TALK_IDX, 2'h0};
  localparam logic [11:0] PFC_LISTEN_ADDR   = {2'h0, PFC_LISTEN_IDX, 2'h0};

  // listen data byte fields
  localparam int          PFC_SEQ_RST_POS   = 3;  // sequencer_reset_bit
  localparam int          PFC_CLEAR_POS     = 5;  // counter_clear_bit
  localparam logic [7:0]  PFC_LISTEN_RST    = 8'h00;

  // status byte fields
  localparam int          PFC_ST_VALID_POS  = 7;
  localparam int          PFC_ST_UP_POS     = 6;
  localparam int          PFC_ST_DOWN_POS   = 5;
  localparam int          PFC_ST_LOCK_POS   = 4;  // lock_status_bit

  // main counter geometry
  localparam int          PFC_STAGE_W       = 4;
  localparam int          PFC_STAGES        = 5;
  localparam int          PFC_COUNT_W       = PFC_STAGE_W * PFC_STAGES;

  // beat prescaler: bit 3 is the div8 tap, bit 4 the div16 tap
  localparam int          PFC_PRE_W         = 5;
  localparam int          PFC_DIV8_POS      = 3;
  localparam int          PFC_DIV16_POS     = 4;

  // readout sequencer positions
  localparam logic [1:0]  PFC_SEQ_STATUS    = 2'h0;
  localparam logic [1:0]  PFC_SEQ_MID       = 2'h1;
  localparam logic [1:0]  PFC_SEQ_LAST      = 2'h2;
  localparam logic [1:0]  PFC_SEQ_IDLE      = 2'h3;

  // clock and lock sensor timing
  localparam int          PFC_CLK_PERIOD_NS = 50;
  localparam int          PFC_LOCK_TMO_US   = 100000;
  localparam int          PFC_LOCK_TMO_CYC  = (PFC_LOCK_TMO_US * 1000) / PFC_CLK_PERIOD_NS;
  localparam int          PFC_LOCK_W        = 24;

endpackage

// [hdl/pfc_edge_sync.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// two-flop synchroniser with edge detection on the settled copy
// ----------------------------------------------------------------------
module pfc_edge_sync
  import pfc_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic async_in,
  output logic      level_out,
  output logic      fall_out,
  output logic      rise_out
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } pfc_sync_t;

  pfc_sync_t st_reg;
  pfc_sync_t st_next;

  // shift chain; meta feeds only sync
  always_comb begin
    st_next      = st_reg;
    st_next.meta = async_in;
    st_next.sync = st_reg.meta;
    st_next.last = st_reg.sync;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.sync;
  assign fall_out  = st_reg.last & ~st_reg.sync;
  assign rise_out  = ~st_reg.last & st_reg.sync;

endmodule

// [hdl/pfc_nibble_stage.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// one four-bit decade-free binary stage of the cascaded counter
// ----------------------------------------------------------------------
module pfc_nibble_stage
  import pfc_pkg::*;
#(
  parameter int W = PFC_STAGE_W
)
(
  input  wire logic         ref_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         clear_in,
  input  wire logic         carry_in,
  output logic [W-1:0]      count_out,
  output logic              carry_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } pfc_stage_t;

  pfc_stage_t st_reg;
  pfc_stage_t st_next;

  // clear wins, otherwise step on carry
  always_comb begin
    st_next = st_reg;
    if (clear_in) begin
      st_next.cnt = '0;
    end else if (carry_in) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count_out = st_reg.cnt;
  assign carry_out = carry_in & (&st_reg.cnt); // ripple to next stage

endmodule

// [sim/pfc_freq_counter_assertions.sv]
`timescale 1ns/1ns
// --------
// port checker
// --------
module pfc_freq_counter_assertions
  import pfc_pkg::*;
#(
  parameter int LOCK_TMO_CYC = 20
)
(
  input wire logic                  ref_clk_in,
  input wire logic                  sys_rst_in,
  input wire logic                  psel_in,
  input wire logic                  penable_in,
  input wire logic                  pwrite_in,
  input wire logic [PFC_ADDR_W-1:0] paddr_in,
  input wire logic [PFC_DATA_W-1:0] pwdata_in,
  input wire logic [PFC_DATA_W-1:0] prdata_out,
  input wire logic                  pready_out,
  input wire logic                  pslverr_out,
  input wire logic                  search_osc_in,
  input wire logic                  drift_up_in,
  input wire logic                  drift_down_in,
  input wire logic                  drift_up_out,
  input wire logic                  drift_down_out,
  input wire logic                  lock_out,
  input wire logic                  count_complete_out,
  input wire logic                  talk_select_strobe_n_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic acc, talk, lsn, clr, osc_q;
  int   quiet;
  // decoded bus phases
  assign acc  = psel_in && penable_in;
  assign talk = paddr_in == PFC_TALK_ADDR;
  assign lsn  = paddr_in == PFC_LISTEN_ADDR;
  assign clr  = acc && pwrite_in && lsn && pwdata_in[PFC_CLEAR_POS];
  // cycles since the search line last moved
  always_ff @(posedge ref_clk_in) begin
    osc_q <= search_osc_in;
    if (sys_rst_in || search_osc_in != osc_q) quiet <= 0;
    else if (quiet < 1000) quiet <= quiet + 1;
  end
  property p_ready;       pready_out; endproperty
  property p_err;         acc && !talk && !lsn |-> pslverr_out; endproperty
  property p_no_err;      acc && (talk || lsn) |-> !pslverr_out; endproperty
  property p_strobe_on;   acc && !pwrite_in && talk |-> !talk_select_strobe_n_out; endproperty
  property p_strobe_off;  !talk_select_strobe_n_out |-> acc && !pwrite_in && talk; endproperty
  property p_clear;       clr |=> !count_complete_out; endproperty
  property p_hold;        count_complete_out && !clr |=> count_complete_out; endproperty
  property p_upper;       prdata_out[31:8] == 24'h000000; endproperty
  property p_drift;
    drift_up_out == (drift_up_in && lock_out) && drift_down_out == (drift_down_in && lock_out);
  endproperty
  property p_lock_fall;   search_osc_in != osc_q |-> ##[1:5] !lock_out; endproperty
  property p_lock_rise;   $rose(lock_out) |-> quiet inside {[LOCK_TMO_CYC - 2 : LOCK_TMO_CYC + 8]}; endproperty
  property p_lock_late;   quiet == LOCK_TMO_CYC + 8 |-> lock_out; endproperty
  a_ready:      assert property (p_ready) else $error("pready low");
  a_err:        assert property (p_err) else $error("no error on unmapped");
  a_no_err:     assert property (p_no_err) else $error("error on mapped");
  a_strobe_on:  assert property (p_strobe_on) else $error("strobe not low");
  a_strobe_off: assert property (p_strobe_off) else $error("strobe stuck");
  a_clear:      assert property (p_clear) else $error("clear ignored");
  a_hold:       assert property (p_hold) else $error("complete lost");
  a_upper:      assert property (p_upper) else $error("upper data set");
  a_drift:      assert property (p_drift) else $error("drift mask wrong");
  a_lock_fall:  assert property (p_lock_fall) else $error("lock kept");
  a_lock_rise:  assert property (p_lock_rise) else $error("lock timing");
  a_lock_late:  assert property (p_lock_late) else $error("lock missing");
  c_complete:   cover property ($rose(count_complete_out));
  c_lock:       cover property ($rose(lock_out));
  c_strobe:     cover property (!talk_select_strobe_n_out);
endmodule

// [sim/pfc_analog_model.sv]
`timescale 1ns/1ns
// --------
// beat and search oscillation sources
// --------
module pfc_analog_model
(
  input  wire logic ref_clk_in,
  output logic      error_beat_out,
  output logic      search_osc_out
);
  // lines rest still between bursts
  initial begin
    error_beat_out = 1'b1;
    search_osc_out = 1'b0;
  end
  // n beat periods of p clocks, one falling edge each
  task automatic beat_run(input int p, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_in);
      error_beat_out <= 1'b0;
      repeat (p / 2) @(posedge ref_clk_in);
      error_beat_out <= 1'b1;
      repeat (p - p / 2 - 1) @(posedge ref_clk_in);
    end
  endtask
  // n toggles, h clocks apart
  task automatic search_run(input int h, input int n);
    repeat (n) begin
      repeat (h) @(posedge ref_clk_in);
      search_osc_out <= ~search_osc_out;
    end
  endtask
endmodule

// [sim/pfc_freq_counter_bench.sv]
`timescale 1ns/1ns
module pfc_freq_counter_bench
  import pfc_pkg::*;
;
  localparam int LOCK = 20;
  logic        ref_clk_in, sys_rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic        error_beat_in, search_osc_in, drift_up_in, drift_down_in, drift_up_out, drift_down_out;
  logic        lock_out, count_complete_out, talk_select_strobe_n_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  int          n_fail, num_checks;
  // --------
  // clock, design and far side
  // --------
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  pfc_freq_counter #(.LOCK_TMO_CYC(LOCK)) dut (.ref_clk_in, .sys_rst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .error_beat_in,
    .search_osc_in, .drift_up_in, .drift_down_in, .drift_up_out, .drift_down_out, .lock_out,
    .count_complete_out, .talk_select_strobe_n_out);
  pfc_analog_model model (.ref_clk_in, .error_beat_out(error_beat_in), .search_osc_out(search_osc_in));
  // --------
  // tasks
  // --------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] rd,
                     output logic err);
    int   i;
    @(posedge ref_clk_in);
    psel_in    <= 1'b1;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= {24'h000000, d};
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_in);
      if (pready_out === 1'b1) begin
        rd  = prdata_out;
        err = pslverr_out;
        break;
      end
    end
    if (i == 20) begin
      chk("pready wait", 32'h1, 32'h0);
      finish_test();
    end
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr_lsn(input logic [7:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, PFC_LISTEN_ADDR, d, rd, e);
  endtask
  task automatic rd_talk(output logic [31:0] rd);
    logic e;
    apb(1'b0, PFC_TALK_ADDR, 8'h00, rd, e);
  endtask
  task automatic status(output logic [31:0] s);
    wr_lsn(8'h08);
    rd_talk(s);
  endtask
  // clear, gate p clock beats, poll, read three bytes
  task automatic run_count(input int p, input bit mid);
    logic [31:0] s, b2, b3, b4;
    logic [19:0] c;
    int          k;
    c = 20'(8 * p);
    wr_lsn(8'h20);
    status(s);
    chk("complete after clear", 32'h0, {31'h0, s[7]});
    fork
      model.beat_run(p, 30);
      begin
        if (mid) begin
          repeat (12 * p) @(posedge ref_clk_in);
          wr_lsn(8'h20);
        end
        s = 32'h0;
        for (k = 0; k < 400 && s[7] !== 1'b1; k++) status(s);
        chk("complete seen", 32'h1, {31'h0, s[7]});
        if (s[7] !== 1'b1) finish_test();
        chk("polls before complete", 32'h1, {31'h0, k > 1});
      end
    join
    status(s);
    rd_talk(b2);
    rd_talk(b3);
    rd_talk(b4);
    chk("status byte", {24'h0, 4'h9, c[19:16]}, s);
    chk("second byte", {24'h0, c[15:8]}, b2);
    chk("last byte", {24'h0, c[7:0]}, b3);
    chk("after last", 32'h0, b4);
    status(s);
    chk("status again", {24'h0, 4'h9, c[19:16]}, s);
    $display("test count period %0d done", p);
  endtask
  // --------
  // main sequence
  // --------
  initial begin
    logic [31:0] rd;
    logic        e;
    int          k;
    n_fail = 0;
    num_checks = 0;
    sys_rst_in = 1'b1;
    {psel_in, penable_in, pwrite_in, drift_up_in, drift_down_in} = 5'h00;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    repeat (5) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(negedge ref_clk_in);
    chk("reset complete", 32'h0, {31'h0, count_complete_out});
    chk("reset lock", 32'h1, {31'h0, lock_out});
    chk("reset strobe", 32'h1, {31'h0, talk_select_strobe_n_out});
    apb(1'b0, 12'h010, 8'h00, rd, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, rd);
    wr_lsn(8'h08);
    apb(1'b1, PFC_TALK_ADDR, 8'h28, rd, e);
    chk("talk write error", 32'h0, {31'h0, e});
    apb(1'b0, PFC_LISTEN_ADDR, 8'h00, rd, e);
    chk("listen readback", 32'h08, rd);
    $display("test bus map done");
    run_count(10, 1'b0);
    run_count(13, 1'b1);
    @(posedge ref_clk_in);
    drift_up_in   <= 1'b1;
    drift_down_in <= 1'b1;
    fork
      model.search_run(4, 40);
      begin
        repeat (20) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk("search lock", 32'h0, {31'h0, lock_out});
        chk("search up", 32'h0, {31'h0, drift_up_out});
        chk("search down", 32'h0, {31'h0, drift_down_out});
        status(rd);
        chk("search status", 32'hE0, rd);
      end
    join
    for (k = 0; k < LOCK + 20 && lock_out !== 1'b1; k++) @(negedge ref_clk_in);
    chk("lock delay", 32'h1, {31'h0, k >= LOCK && k <= LOCK + 6});
    if (lock_out !== 1'b1) finish_test();
    chk("locked up", 32'h1, {31'h0, drift_up_out});
    chk("locked down", 32'h1, {31'h0, drift_down_out});
    status(rd);
    chk("locked status", 32'hF0, rd);
    $display("test lock done");
    finish_test();
  end
endmodule
bind pfc_freq_counter pfc_freq_counter_assertions #(.LOCK_TMO_CYC(LOCK_TMO_CYC)) chk_i (.ref_clk_in,
  .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
  .pslverr_out, .search_osc_in, .drift_up_in, .drift_down_in, .drift_up_out, .drift_down_out,
  .lock_out, .count_complete_out, .talk_select_strobe_n_out);
